// >>> src/ready_latch.sv
// ready pin, two-stage channel result latch and continuous write loop
// assumes the spi front end, converter core and checksum logic all run on clk_in
`timescale 1ns/1ps
`default_nettype none
module ready_latch (
	input  wire logic                         clk_in,
	input  wire logic                         resetn_in,
	// spi front end
	input  wire logic                         cs_n_in,
	input  wire logic                         ctrl_valid_in,
	input  wire logic [ready_pkg::ADDR_W-1:0] ctrl_addr_in,
	input  wire logic                         ctrl_write_in,
	input  wire logic                         wr_valid_in,
	input  wire logic [ready_pkg::DATA_W-1:0] wr_data_in,
	output logic                              wr_ready_out,
	output logic                              sdo_oe_out,
	input  wire logic                         read_start_in,
	input  wire logic [1:0]                   read_chan_in,
	output logic [ready_pkg::DATA_W-1:0]      read_word_out,
	output logic [3:0]                        channel_ready_flags_out,
	// converter core
	input  wire logic                         sample_rate_tick_in,
	input  wire logic [3:0]                   conv_done_in,
	input  wire logic [3:0][ready_pkg::DATA_W-1:0] ch_result_in,
	input  wire logic [15:0]                  settle_cycles_in,
	input  wire logic [3:0]                   soft_reset_in,
	input  wire logic [3:0]                   shutdown_in,
	input  wire logic                         cfg_checksum_flag_in,
	output logic [3:0]                        restart_out,
	output logic [2:0]                        oversampling_ratio_sel_out,
	output logic [1:0]                        clock_prescaler_sel_out,
	output logic                              external_clock_sel_out,
	output logic                              external_reference_sel_out,
	// sample-ready pin
	output logic                              sample_ready_pin_out,
	output logic                              sample_ready_pin_oe_out
);
	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		ready_pkg::sess_e                      sess;
		logic [ready_pkg::ADDR_W-1:0]          ptr;
		logic [ready_pkg::PHASE_W-1:0]         phase;
		logic [2:0]                            osr;
		logic [1:0]                            pre;
		logic                                  external_clock_sel;
		logic                                  external_reference_sel;
		logic                                  write_loop;
		logic                                  idle_drive;
		logic                                  link;
		logic [7:0]                            lock;
		logic                                  reload;
		logic                                  armed;
		logic [ready_pkg::SETTLE_W-1:0]        settle_cnt;
		logic [ready_pkg::PULSE_W-1:0]         pulse_cnt;
		logic                                  pin_out;
		logic                                  pin_oe;
		logic [3:0]                            flags;
		logic [3:0][ready_pkg::DATA_W-1:0]     stage1;
		logic [ready_pkg::DATA_W-1:0]          rd_word;
		logic [3:0]                            restart;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	word_if wbuf_in ();
	word_if wbuf_out ();

	logic       writable;
	logic       push_ok;
	logic       apply;
	logic [4:0] apply_addr;
	logic [23:0] apply_data;
	logic [3:0] active;
	logic       fire;
	logic [3:0] capture;
	logic       cfg_change;

	word_buffer u_wbuf (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.push      (wbuf_in.take),
		.pop       (wbuf_out.fill)
	);

	// -------------------------------------------------------------------
	// write loop front
	// -------------------------------------------------------------------
	assign writable = (st_ff.ptr >= ready_pkg::ADDR_WR_FIRST) &&
		((st_ff.lock == ready_pkg::LOCK_KEY) || (st_ff.ptr == ready_pkg::ADDR_LOCK));
	assign wbuf_in.valid = wr_valid_in && (st_ff.sess == ready_pkg::SESS_WRITE) && writable;
	assign wbuf_in.data  = {st_ff.ptr, wr_data_in};
	// words aimed at protected addresses are swallowed so the master never hangs
	assign wr_ready_out  = writable ? wbuf_in.ready : 1'b1;
	assign push_ok       = wbuf_in.valid && wbuf_in.ready;
	// no register change while a restart is being issued
	assign wbuf_out.ready = (st_ff.restart == 4'h0);
	assign apply         = wbuf_out.valid && wbuf_out.ready;
	assign apply_addr    = wbuf_out.data[ready_pkg::WORD_W-1:ready_pkg::DATA_W];
	assign apply_data    = wbuf_out.data[ready_pkg::DATA_W-1:0];

	assign active     = ~(soft_reset_in | shutdown_in);
	assign cfg_change = (apply_data[ready_pkg::CFG_OSR_LSB+:3] != st_ff.osr) ||
		(apply_data[ready_pkg::CFG_PRE_LSB+:2] != st_ff.pre) ||
		(apply_data[ready_pkg::CFG_EXTERNAL_CLOCK_SEL] != st_ff.external_clock_sel) ||
		(apply_data[ready_pkg::CFG_EXTERNAL_REFERENCE_SEL] != st_ff.external_reference_sel);

	// pulse start: at settle expiry, then on every sample-rate tick; chip select unused
	assign fire = (active != 4'h0) && (st_ff.restart == 4'h0) && !st_ff.reload &&
		((st_ff.armed && sample_rate_tick_in) || (!st_ff.armed && st_ff.settle_cnt == '0));

	// linked mode takes all active channels at once, else each on its own done
	assign capture = fire ? (st_ff.link ? active : (active & conv_done_in)) : 4'h0;

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.restart = 4'h0;

		// session tracking: one control byte per chip-select low
		if (cs_n_in) begin
			nxt_st.sess = ready_pkg::SESS_IDLE;
		end else if (ctrl_valid_in && st_ff.sess == ready_pkg::SESS_IDLE) begin
			nxt_st.sess = ctrl_write_in ? ready_pkg::SESS_WRITE : ready_pkg::SESS_READ;
			nxt_st.ptr  = ctrl_addr_in;
		end else if (push_ok && st_ff.write_loop) begin
			if (st_ff.ptr == ready_pkg::ADDR_WR_LAST) begin
				nxt_st.ptr = ready_pkg::ADDR_WR_FIRST;
			end else begin
				nxt_st.ptr = st_ff.ptr + 5'h01;
			end
		end

		// register update from the buffer
		if (apply) begin
			case (apply_addr)
				ready_pkg::ADDR_PHASE: begin
					nxt_st.phase   = apply_data[ready_pkg::PHASE_LSB+:ready_pkg::PHASE_W];
					nxt_st.restart = active;
				end
				ready_pkg::ADDR_STATUS_COMM: begin
					nxt_st.write_loop = apply_data[ready_pkg::SC_WRITE_LOOP];
					nxt_st.idle_drive = apply_data[ready_pkg::SC_IDLE_DRIVE];
					nxt_st.link       = apply_data[ready_pkg::SC_LINK];
				end
				ready_pkg::ADDR_CONFIG: begin
					nxt_st.osr     = apply_data[ready_pkg::CFG_OSR_LSB+:3];
					nxt_st.pre     = apply_data[ready_pkg::CFG_PRE_LSB+:2];
					nxt_st.external_clock_sel  = apply_data[ready_pkg::CFG_EXTERNAL_CLOCK_SEL];
					nxt_st.external_reference_sel = apply_data[ready_pkg::CFG_EXTERNAL_REFERENCE_SEL];
					if (cfg_change) begin
						nxt_st.restart = active;
					end
				end
				ready_pkg::ADDR_LOCK: begin
					nxt_st.lock = apply_data[ready_pkg::LOCK_LSB+:8];
				end
				default: begin
					nxt_st.lock = st_ff.lock;
				end
			endcase
		end

		// settle timing: first pulse after filter settle plus channel delay
		if (st_ff.reload) begin
			nxt_st.reload     = 1'b0;
			nxt_st.armed      = 1'b0;
			nxt_st.settle_cnt = ready_pkg::SETTLE_W'(settle_cycles_in) +
				ready_pkg::SETTLE_W'(st_ff.phase) *
				ready_pkg::SETTLE_W'(ready_pkg::PHASE_UNIT_CYC);
		end else if (fire) begin
			nxt_st.armed = 1'b1;
		end else if (!st_ff.armed && st_ff.settle_cnt != '0) begin
			nxt_st.settle_cnt = st_ff.settle_cnt - ready_pkg::SETTLE_W'(1);
		end

		// low pulse of half a modulator period
		if (fire) begin
			nxt_st.pulse_cnt = ready_pkg::PULSE_W'(ready_pkg::MOD_HALF_CYC);
		end else if (st_ff.pulse_cnt != '0) begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - ready_pkg::PULSE_W'(1);
		end

		// second stage: freeze the requested channel at read start
		if (read_start_in) begin
			nxt_st.rd_word              = st_ff.stage1[read_chan_in];
			nxt_st.flags[read_chan_in]  = 1'b1;
		end

		// first stage: capture wins over a read setting the flag
		for (int ch = 0; ch < ready_pkg::CHANNELS; ch++) begin
			if (capture[ch]) begin
				nxt_st.stage1[ch] = ch_result_in[ch];
				nxt_st.flags[ch]  = 1'b0;
			end
		end

		// restart: reload settle, clear results of restarted channels
		if (st_ff.restart != 4'h0) begin
			nxt_st.reload    = 1'b1;
			nxt_st.armed     = 1'b0;
			// a pulse already on the pin runs to its full width
			for (int ch = 0; ch < ready_pkg::CHANNELS; ch++) begin
				if (st_ff.restart[ch]) begin
					nxt_st.stage1[ch] = '0;
					nxt_st.flags[ch]  = 1'b1;
				end
			end
		end

		// pin drive
		if (cfg_checksum_flag_in) begin
			nxt_st.pin_out = 1'b0;
			nxt_st.pin_oe  = 1'b1;
		end else if (nxt_st.pulse_cnt != '0) begin
			nxt_st.pin_out = 1'b0;
			nxt_st.pin_oe  = 1'b1;
		end else begin
			nxt_st.pin_out = 1'b1;
			nxt_st.pin_oe  = nxt_st.idle_drive;
		end
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_ff            <= '0;
			st_ff.sess       <= ready_pkg::SESS_IDLE;
			st_ff.osr        <= ready_pkg::RST_OSR;
			st_ff.pre        <= ready_pkg::RST_PRE;
			st_ff.write_loop <= ready_pkg::RST_WRITE_LOOP;
			st_ff.idle_drive <= ready_pkg::RST_IDLE_DRIVE;
			st_ff.link       <= ready_pkg::RST_LINK;
			st_ff.lock       <= ready_pkg::RST_LOCK;
			st_ff.reload     <= 1'b1;
			st_ff.flags      <= 4'hf;
			st_ff.pin_out    <= 1'b1;
			st_ff.pin_oe     <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign sdo_oe_out                 = (st_ff.sess == ready_pkg::SESS_READ);
	assign read_word_out              = st_ff.rd_word;
	assign channel_ready_flags_out    = st_ff.flags;
	assign restart_out                = st_ff.restart;
	assign oversampling_ratio_sel_out = st_ff.osr;
	assign clock_prescaler_sel_out    = st_ff.pre;
	assign external_clock_sel_out     = st_ff.external_clock_sel;
	assign external_reference_sel_out = st_ff.external_reference_sel;
	assign sample_ready_pin_out       = st_ff.pin_out;
	assign sample_ready_pin_oe_out    = st_ff.pin_oe;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	ptr_static_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(push_ok && !st_ff.write_loop && !cs_n_in && !ctrl_valid_in) |=> $stable(st_ff.ptr))
		else $error("pointer moved in static write loop");

	ptr_wrap_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(push_ok && st_ff.write_loop && !cs_n_in && !ctrl_valid_in &&
		st_ff.ptr == ready_pkg::ADDR_WR_LAST) |=> (st_ff.ptr == ready_pkg::ADDR_WR_FIRST))
		else $error("pointer did not wrap to first writable address");

	sdo_float_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(st_ff.sess == ready_pkg::SESS_WRITE) |-> !sdo_oe_out)
		else $error("serial output driven during write loop");

	readonly_hold_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(st_ff.sess == ready_pkg::SESS_WRITE && wr_valid_in && !cs_n_in &&
		st_ff.ptr <= ready_pkg::ADDR_RO_LAST) |=> $stable(st_ff.ptr) && !$past(push_ok))
		else $error("read-only write advanced pointer");

	lock_gate_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(push_ok && st_ff.lock != ready_pkg::LOCK_KEY) |-> (st_ff.ptr == ready_pkg::ADDR_LOCK))
		else $error("write accepted while locked");

	phase_restart_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(apply && apply_addr == ready_pkg::ADDR_PHASE) |=> (restart_out == $past(active)))
		else $error("delay write did not restart converters");

	restart_clear_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		restart_out[0] |=> (st_ff.stage1[0] == '0) && st_ff.reload)
		else $error("restart did not clear result or resume");

	pulse_width_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(fire && !cfg_checksum_flag_in) |=> (!sample_ready_pin_out && sample_ready_pin_oe_out)[*2]
		##1 (sample_ready_pin_out || $past(cfg_checksum_flag_in) || $past(fire)))
		else $error("ready pulse width wrong");

	idle_drive_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		sample_ready_pin_out |-> (sample_ready_pin_oe_out == st_ff.idle_drive))
		else $error("idle ready pin drive wrong");

	checksum_low_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		cfg_checksum_flag_in |=> (sample_ready_pin_oe_out && !sample_ready_pin_out))
		else $error("ready pin not held low on checksum flag");

	link_capture_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(fire && st_ff.link && active[2] && st_ff.restart == 4'h0)
		|=> (st_ff.stage1[2] == $past(ch_result_in[2])) && !channel_ready_flags_out[2])
		else $error("linked capture missed a channel");

	read_freeze_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		read_start_in |=> (read_word_out == $past(st_ff.stage1[read_chan_in])))
		else $error("read start did not freeze channel result");
endmodule : ready_latch
`default_nettype wire

// >>> src/ready_pkg.sv
// package of constants, state codes and field positions for the ready latch block
// assumes one 20 MHz system clock; the spi front end delivers whole control bytes and words
package ready_pkg;
	localparam int          CHANNELS          = 4;
	localparam int          DATA_W            = 24;
	localparam int          ADDR_W            = 5;
	localparam int          WORD_W            = ADDR_W + DATA_W;
	localparam int          SETTLE_W          = 20;
	localparam int          PULSE_W           = 3;

	// timing
	localparam int          CLK_PERIOD_NS     = 50;
	localparam int          MOD_CLK_PERIOD_NS = 200;
	localparam int          MOD_HALF_CYC      = (MOD_CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam int          PHASE_UNIT_NS     = 1000;
	localparam int          PHASE_UNIT_CYC    = PHASE_UNIT_NS / CLK_PERIOD_NS;

	// register addresses
	localparam logic [4:0]  ADDR_RO_LAST      = 5'h07;
	localparam logic [4:0]  ADDR_WR_FIRST     = 5'h08;
	localparam logic [4:0]  ADDR_WR_LAST      = 5'h1f;
	localparam logic [4:0]  ADDR_PHASE        = 5'h0a;
	localparam logic [4:0]  ADDR_STATUS_COMM  = 5'h0b;
	localparam logic [4:0]  ADDR_CONFIG       = 5'h0c;
	localparam logic [4:0]  ADDR_LOCK         = 5'h1f;
	localparam logic [7:0]  LOCK_KEY          = 8'ha5;

	// field positions
	localparam int          PHASE_LSB         = 0;
	localparam int          PHASE_W           = 12;
	localparam int          SC_WRITE_LOOP     = 0;
	localparam int          SC_IDLE_DRIVE     = 1;
	localparam int          SC_LINK           = 2;
	localparam int          CFG_OSR_LSB       = 0;
	localparam int          CFG_PRE_LSB       = 3;
	localparam int          CFG_EXTERNAL_CLOCK_SEL        = 5;
	localparam int          CFG_EXTERNAL_REFERENCE_SEL       = 6;
	localparam int          LOCK_LSB          = 16;

	// reset values
	localparam logic        RST_WRITE_LOOP    = 1'b1;
	localparam logic        RST_IDLE_DRIVE    = 1'b0;
	localparam logic        RST_LINK          = 1'b1;
	localparam logic [2:0]  RST_OSR           = 3'h3;
	localparam logic [1:0]  RST_PRE           = 2'h0;
	localparam logic [7:0]  RST_LOCK          = 8'ha5;

	typedef enum logic [1:0] {
		SESS_IDLE  = 2'b00,
		SESS_WRITE = 2'b01,
		SESS_READ  = 2'b10
	} sess_e;
endpackage : ready_pkg

// >>> src/word_if.sv
// carrier for one address-tagged register write word between buffer and its neighbours
// assumes valid/ready handshake: a word moves on an edge where both are high
`timescale 1ns/1ps
`default_nettype none
interface word_if;
	logic                            valid;
	logic                            ready;
	logic [ready_pkg::WORD_W-1:0]    data;

	modport fill  (output valid, output data, input ready);
	modport take  (input valid, input data, output ready);
endinterface : word_if
`default_nettype wire

// >>> src/word_buffer.sv
// two-entry buffer for register write words
// assumes the drain side may stall at any time; nothing is lost while it does
`timescale 1ns/1ps
`default_nettype none
module word_buffer (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	word_if.take      push,
	word_if.fill      pop
);
	typedef struct packed {
		logic [1:0][ready_pkg::WORD_W-1:0] slot;
		logic                              wr;
		logic                              rd;
		logic [1:0]                        count;
	} buf_s;

	buf_s st_ff;
	buf_s nxt_st;
	logic do_push;
	logic do_pop;

	assign push.ready = (st_ff.count != 2'h2);
	assign pop.valid  = (st_ff.count != 2'h0);
	assign pop.data   = st_ff.slot[st_ff.rd];
	assign do_push    = push.valid && push.ready;
	assign do_pop     = pop.valid && pop.ready;

	always_comb begin
		nxt_st = st_ff;
		if (do_push) begin
			nxt_st.slot[st_ff.wr] = push.data;
			nxt_st.wr             = ~st_ff.wr;
		end
		if (do_pop) begin
			nxt_st.rd = ~st_ff.rd;
		end
		if (do_push && !do_pop) begin
			nxt_st.count = st_ff.count + 2'h1;
		end else if (!do_push && do_pop) begin
			nxt_st.count = st_ff.count - 2'h1;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	no_overflow_a : assert property (@(posedge clk_in) disable iff (!resetn_in)
		(st_ff.count == 2'h2 && !do_pop) |=> (st_ff.count == 2'h2))
		else $error("buffer lost its fill level");
endmodule : word_buffer
`default_nettype wire

// >>> verification/conv_core_model.sv
// converter core stand-in: sample-rate tick and channel results
// assumes the block's clk_in; results only move a few cycles after a tick
`timescale 1ns/1ps
`default_nettype none
module conv_core_model #(
	parameter int PERIOD = 40
) (
	input  wire logic                         clk_in,
	input  wire logic                         resetn_in,
	output logic                              tick_out,
	output logic [3:0][ready_pkg::DATA_W-1:0] result_out
);
	int         cnt_ff;
	logic [7:0] seq_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_ff <= 0;
			seq_ff <= 8'h00;
		end else begin
			cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
			if (cnt_ff == 3)
				seq_ff <= seq_ff + 8'h01;
		end
	end

	// one pulse per sample-rate period, so results are steady around every tick
	assign tick_out = (cnt_ff == PERIOD - 1);

	always_comb begin
		for (int c = 0; c < 4; c++)
			result_out[c] = {8'(c + 1), 8'h00, seq_ff};
	end
endmodule : conv_core_model
`default_nettype wire

// >>> verification/tb_adc_ready_latch_and_write_loop.sv
// self-checking bench for the ready pin, result latch and write loop
// assumes conv_core_model as converter core; the bench plays the spi host
`timescale 1ns/1ps
`default_nettype none
module tb_adc_ready_latch_and_write_loop;
	localparam int SETTLE = 30;
	logic                              clk_in, resetn_in, cs_n_in, ctrl_valid_in, ctrl_write_in;
	logic                              wr_valid_in, read_start_in, cfg_checksum_flag_in, tick;
	logic [4:0]                        ctrl_addr_in;
	logic [23:0]                       wr_data_in, read_word_out, exp_word, held;
	logic [1:0]                        read_chan_in, pre;
	logic [3:0]                        conv_done_in, soft_reset_in, flags, restart_out, last_restart;
	logic [3:0]                        shut;
	logic [15:0]                       settle_cycles_in;
	logic [3:0][ready_pkg::DATA_W-1:0] ch_result_in;
	logic [2:0]                        osr;
	logic                              wr_ready_out, sdo_oe_out, external_clock_sel, external_reference_sel, pin, pin_oe, pin_prev;
	int                                n_errors, num_checks, cycles, last_fall, fall_gap, n;

	ready_latch u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in),
		.ctrl_valid_in(ctrl_valid_in), .ctrl_addr_in(ctrl_addr_in), .ctrl_write_in(ctrl_write_in),
		.wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out),
		.sdo_oe_out(sdo_oe_out), .read_start_in(read_start_in), .read_chan_in(read_chan_in),
		.read_word_out(read_word_out), .channel_ready_flags_out(flags),
		.sample_rate_tick_in(tick), .conv_done_in(conv_done_in), .ch_result_in(ch_result_in),
		.settle_cycles_in(settle_cycles_in), .soft_reset_in(soft_reset_in), .shutdown_in(shut),
		.cfg_checksum_flag_in(cfg_checksum_flag_in), .restart_out(restart_out),
		.oversampling_ratio_sel_out(osr), .clock_prescaler_sel_out(pre),
		.external_clock_sel_out(external_clock_sel), .external_reference_sel_out(external_reference_sel),
		.sample_ready_pin_out(pin), .sample_ready_pin_oe_out(pin_oe));

	conv_core_model u_core (.clk_in(clk_in), .resetn_in(resetn_in), .tick_out(tick),
		.result_out(ch_result_in));

	// ----------------------------------------
	// clock, timeout and monitors
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			complete_run();
		end
	end

	always @(negedge clk_in) begin
		if (restart_out !== 4'h0)
			last_restart = restart_out;
		if (pin === 1'b0 && pin_prev === 1'b1) begin
			fall_gap = cycles - last_fall;
			last_fall = cycles;
		end
		pin_prev = pin;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// one control byte after select, then words on the valid/ready handshake
	task automatic write_session(input logic [4:0] addr, input int cnt, input logic [23:0] w0,
		input logic [23:0] w1);
		int k;
		@(posedge clk_in);
		cs_n_in <= 1'b0;
		@(posedge clk_in);
		ctrl_valid_in <= 1'b1;
		ctrl_write_in <= 1'b1;
		ctrl_addr_in <= addr;
		@(posedge clk_in);
		ctrl_valid_in <= 1'b0;
		for (int i = 0; i < cnt; i++) begin
			wr_valid_in <= 1'b1;
			wr_data_in <= (i == 0) ? w0 : w1;
			k = 0;
			@(negedge clk_in);
			while (wr_ready_out !== 1'b1 && k < 50) begin
				@(negedge clk_in);
				k++;
			end
			check("sdo_oe", sdo_oe_out, 1'b0);
			@(posedge clk_in);
		end
		wr_valid_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		cs_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask : write_session

	// one read at a time, started well after the pin fell
	task automatic read_chan(input logic [1:0] ch);
		@(posedge clk_in);
		read_start_in <= 1'b1;
		read_chan_in <= ch;
		@(posedge clk_in);
		read_start_in <= 1'b0;
		@(negedge clk_in);
	endtask : read_chan

	task automatic pulse(input logic exp_oe, input logic [2:0] exp_fl, output int fall_n);
		int w;
		fall_n = 0;
		w = 0;
		@(negedge clk_in);
		while (pin !== 1'b0 && fall_n < 400) begin
			@(negedge clk_in);
			fall_n++;
		end
		check("fall_seen", fall_n < 400, 1'b1);
		check("fresh_flags", flags[2:0], exp_fl);
		exp_word = ch_result_in[2];
		while (pin === 1'b0 && w < 10) begin
			@(negedge clk_in);
			w++;
		end
		check("low_width", w, ready_pkg::MOD_HALF_CYC);
		check("idle_pin", {pin, pin_oe}, {1'b1, exp_oe});
	endtask : pulse

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{resetn_in, ctrl_valid_in, ctrl_write_in, wr_valid_in, read_start_in} = '0;
		{cfg_checksum_flag_in, ctrl_addr_in, wr_data_in, read_chan_in} = '0;
		{n_errors, num_checks, cycles, last_fall, fall_gap} = '0;
		cs_n_in = 1'b1;
		conv_done_in = 4'hf;
		soft_reset_in = 4'h8;
		shut = 4'h0;
		settle_cycles_in = 16'(SETTLE);
		last_restart = 4'h0;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		check("oe_in_reset", pin_oe, 1'b0);
		check("flags_rst", flags, 4'hf);
		check("cfg_rst", {osr, pre, external_clock_sel, external_reference_sel, restart_out, sdo_oe_out}, 12'h600);
		@(posedge clk_in);
		resetn_in <= 1'b1;
		pulse(1'b0, 3'h0, n);
		check("first_fall", n >= SETTLE && n <= SETTLE + 3, 1'b1);
		read_chan(2'd2);
		check("read_word", read_word_out, exp_word);
		check("flag_taken", flags[2], 1'b1);
		held = exp_word;
		// the first tick pulse follows the settle pulse at no fixed distance
		pulse(1'b0, 3'h0, n);
		pulse(1'b0, 3'h0, n);
		check("frozen", read_word_out, held);
		check("newer_result", exp_word != held, 1'b1);
		check("tick_gap", fall_gap, 40);
		write_session(ready_pkg::ADDR_STATUS_COMM, 2, 24'h000007, 24'h000005);
		check("step_osr", osr, 3'h5);
		check("restart_cfg", last_restart, 4'h7);
		read_chan(2'd0);
		check("cleared", read_word_out, 24'h0);
		pulse(1'b1, 3'h0, n);
		write_session(ready_pkg::ADDR_STATUS_COMM, 1, 24'h000006, 24'h000000);
		write_session(ready_pkg::ADDR_STATUS_COMM, 2, 24'h000006, 24'h000007);
		check("static_osr", osr, 3'h5);
		last_restart = 4'h0;
		write_session(5'h07, 6, 24'h000002, 24'h000002);
		check("ro_osr", osr, 3'h5);
		check("ro_restart", last_restart, 4'h0);
		write_session(ready_pkg::ADDR_LOCK, 1, 24'h000000, 24'h000000);
		write_session(ready_pkg::ADDR_CONFIG, 1, 24'h000001, 24'h000000);
		check("locked_osr", osr, 3'h5);
		write_session(ready_pkg::ADDR_LOCK, 1, 24'ha50000, 24'h000000);
		write_session(ready_pkg::ADDR_CONFIG, 1, 24'h000001, 24'h000000);
		check("unlocked_osr", osr, 3'h1);
		last_restart = 4'h0;
		shut <= 4'h1;
		write_session(ready_pkg::ADDR_PHASE, 1, 24'h000000, 24'h000000);
		check("restart_phase", last_restart, 4'h6);
		shut <= 4'h0;
		@(posedge clk_in);
		cs_n_in <= 1'b0;
		pulse(1'b1, 3'h0, n);
		@(posedge clk_in);
		cs_n_in <= 1'b1;
		pulse(1'b1, 3'h0, n);
		pulse(1'b1, 3'h0, n);
		check("resume_gap", fall_gap, 40);
		// unlinked capture: channel 1 is not done, so its flag stays set
		read_chan(2'd1);
		@(posedge clk_in);
		conv_done_in <= 4'h5;
		write_session(ready_pkg::ADDR_STATUS_COMM, 1, 24'h000003, 24'h000000);
		pulse(1'b1, 3'h2, n);
		@(posedge clk_in);
		cfg_checksum_flag_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		check("crc_low", {pin, pin_oe}, 2'b01);
		repeat (60) @(negedge clk_in);
		check("crc_held", {pin, pin_oe}, 2'b01);
		@(posedge clk_in);
		resetn_in <= 1'b0;
		@(negedge clk_in);
		check("reset_pin", {pin, pin_oe}, 2'b10);
		complete_run();
	end
endmodule : tb_adc_ready_latch_and_write_loop
`default_nettype wire
